// ===== hdl/gpp_pkg.sv
// Constants and types shared by the general purpose pin port block
package gpp_pkg;

  localparam int NPORT = 4;
  localparam int PIN_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [3:0][7:0] IDX_DIR = {8'hF4, 8'hF0, 8'hE4, 8'hE0};
  localparam logic [3:0][7:0] IDX_DATA = {8'hF5, 8'hF1, 8'hE5, 8'hE1};
  localparam logic [3:0][7:0] IDX_INV = {8'hF6, 8'hF2, 8'hE6, 8'hE2};
  localparam logic [3:0][7:0] IDX_STAT = {8'hF7, 8'hE8, 8'hE7, 8'hE3};
  localparam logic [3:0][7:0] IDX_FSEL = {8'hEB, 8'hEE, 8'hEA, 8'hE9};
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF9;

  // Implemented pins per port and direction reset values
  localparam logic [3:0][7:0] PIN_MASK = {8'hFF, 8'hFF, 8'h7F, 8'hFF};
  localparam logic [3:0][7:0] DIR_RST = {8'hFF, 8'hFF, 8'h7F, 8'hFF};

  // Alternate signal codes
  localparam logic [2:0] S_GRN = 3'h0;
  localparam logic [2:0] S_YLW = 3'h1;
  localparam logic [2:0] S_BEEP = 3'h2;
  localparam logic [2:0] S_SMI = 3'h3;
  localparam logic [2:0] S_OVT = 3'h4;
  localparam logic [2:0] S_WDT = 3'h5;
  localparam logic [2:0] S_S5 = 3'h6;
  localparam logic [2:0] S_NONE = 3'h7;

  // Alternate source per pin, bit 7 first
  localparam logic [3:0][23:0] FSEL_SRC = {
    {S_YLW, S_GRN, S_S5, S_WDT, S_YLW, S_GRN, S_YLW, S_GRN},
    {S_YLW, S_BEEP, S_SMI, S_WDT, S_YLW, S_BEEP, S_SMI, S_WDT},
    {S_NONE, S_GRN, S_BEEP, S_SMI, S_WDT, S_GRN, S_BEEP, S_SMI},
    {S_GRN, S_BEEP, S_SMI, S_OVT, S_GRN, S_BEEP, S_SMI, S_WDT}};

  typedef enum logic [3:0] {
    K_NONE, K_ACT, K_DIR, K_DATA, K_INV, K_STAT, K_FSEL, K_IST, K_IMSK
  } gpp_kind_t;

  typedef struct packed {
    logic hit;
    gpp_kind_t kind;
    logic [1:0] port;
  } gpp_dec_t;

  typedef struct packed {
    logic [3:0] act;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] data;
    logic [3:0][7:0] inv;
    logic [3:0][7:0] stat;
    logic [3:0][7:0] fsel;
    logic [3:0][7:0] prev;
    logic primed;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0][7:0] pout;
    logic [3:0][7:0] poe;
    logic irq;
  } gpp_state_t;

  localparam gpp_state_t RST_STATE = '{dir: DIR_RST, default: '0};

endpackage

// ===== hdl/gpp_ports.sv
// General purpose pin ports two to five with APB register access
// Notes on behaviour
// - Activation bits 3..0 enable ports five, four, three, two; upper bits reserved.
// - Direction bit 0 means output, 1 input; resets to ones on every implemented pin.
// - Port three has pins 6..0 only; bit 7 reserved, direction resets 7Fh.
// - Output pin data bits are read/write and drive the pin; reset zero.
// - Input pin data bits read the pin level; writes to them are ignored.
// - Inversion bit set inverts register bit versus pin, both directions.
// - An edge on an enabled pin sets its status bit; resets zero.
// - Reading a status register clears the bits read; never writable.
// - Port two selects: green, beeper, mgmt interrupt, overtemp, watchdog.
// - Port three selects: green, beeper, mgmt interrupt, watchdog; bit 7 reserved.
// - Port five selects: yellow, green, S5 sleep latch, watchdog.
// - Port four bits 7..2 select yellow, beeper, mgmt interrupt, watchdog.
// - Port four bit 1 routes mgmt interrupt, bit 0 routes watchdog.
// - Port five has full direction, data, inversion and status registers.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module gpp_ports #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_two_reset,
  input wire logic port_three_reset,
  input wire logic port_four_reset,
  input wire logic port_five_reset,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  input wire logic green_led_out,
  input wire logic yellow_led_out,
  input wire logic beeper_out,
  input wire logic sys_mgmt_irq_out,
  input wire logic over_temp_out,
  input wire logic watchdog_expire_out,
  input wire logic sleep_s5_latch_out,
  output logic irq
);

  gpp_pkg::gpp_state_t s_ff;
  gpp_pkg::gpp_state_t nxt_s;
  gpp_pkg::gpp_dec_t dec;
  logic [7:0] rv;
  logic [7:0] wd;
  logic [31:0] edge_v;
  logic [7:0] alt_v;
  logic [3:0] prst_v;
  logic acc_prep;
  logic acc_done;

  // Register index decode
  function automatic gpp_pkg::gpp_dec_t decode(input logic [ADDR_W-1:0] a);
    gpp_pkg::gpp_dec_t d;
    logic [7:0] idx;
    d.hit = 1'b0;
    d.kind = gpp_pkg::K_NONE;
    d.port = 2'h0;
    idx = a[9:2];
    if (a[1:0] == 2'h0 && (a >> 10) == '0) begin
      if (idx == gpp_pkg::IDX_ACT) begin
        d.hit = 1'b1;
        d.kind = gpp_pkg::K_ACT;
      end
      if (idx == gpp_pkg::IDX_IRQ_STAT) begin
        d.hit = 1'b1;
        d.kind = gpp_pkg::K_IST;
      end
      if (idx == gpp_pkg::IDX_IRQ_MASK) begin
        d.hit = 1'b1;
        d.kind = gpp_pkg::K_IMSK;
      end
      for (int p = 0; p < gpp_pkg::NPORT; p++) begin
        if (idx == gpp_pkg::IDX_DIR[p]) begin
          d.hit = 1'b1;
          d.kind = gpp_pkg::K_DIR;
          d.port = 2'(p);
        end
        if (idx == gpp_pkg::IDX_DATA[p]) begin
          d.hit = 1'b1;
          d.kind = gpp_pkg::K_DATA;
          d.port = 2'(p);
        end
        if (idx == gpp_pkg::IDX_INV[p]) begin
          d.hit = 1'b1;
          d.kind = gpp_pkg::K_INV;
          d.port = 2'(p);
        end
        if (idx == gpp_pkg::IDX_STAT[p]) begin
          d.hit = 1'b1;
          d.kind = gpp_pkg::K_STAT;
          d.port = 2'(p);
        end
        if (idx == gpp_pkg::IDX_FSEL[p]) begin
          d.hit = 1'b1;
          d.kind = gpp_pkg::K_FSEL;
          d.port = 2'(p);
        end
      end
    end
    return d;
  endfunction

  assign dec = decode(paddr);
  assign wd = pwdata[7:0];
  assign prst_v = {port_five_reset, port_four_reset, port_three_reset, port_two_reset};
  assign alt_v = {1'b0, sleep_s5_latch_out, watchdog_expire_out, over_temp_out,
                  sys_mgmt_irq_out, beeper_out, yellow_led_out, green_led_out};
  assign acc_prep = psel && penable && !s_ff.pready;
  assign acc_done = psel && penable && s_ff.pready;

  // Read value of the addressed register
  always_comb begin
    rv = '0;
    case (dec.kind)
      gpp_pkg::K_ACT: rv = {4'h0, s_ff.act};
      gpp_pkg::K_DIR: rv = s_ff.dir[dec.port];
      gpp_pkg::K_DATA: rv = ((s_ff.data[dec.port] & ~s_ff.dir[dec.port])
                            | ((pin_in[dec.port*8 +: 8] ^ s_ff.inv[dec.port])
                            & s_ff.dir[dec.port])) & gpp_pkg::PIN_MASK[dec.port];
      gpp_pkg::K_INV: rv = s_ff.inv[dec.port];
      gpp_pkg::K_STAT: rv = s_ff.stat[dec.port];
      gpp_pkg::K_FSEL: rv = s_ff.fsel[dec.port];
      gpp_pkg::K_IST: rv = {4'h0, s_ff.irq_st};
      gpp_pkg::K_IMSK: rv = {4'h0, s_ff.irq_mask};
      default: rv = '0;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    edge_v = '0;
    nxt_s.primed = 1'b1;
    nxt_s.irq = |(s_ff.irq_st & s_ff.irq_mask);
    // APB answer one cycle into the access phase
    if (acc_prep) begin
      nxt_s.pready = 1'b1;
      nxt_s.pslverr = !dec.hit;
      nxt_s.prdata = (pwrite || !dec.hit) ? 32'h0000_0000 : {24'h00_0000, rv};
    end
    if (acc_done) begin
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (pwrite && dec.hit) begin
        case (dec.kind)
          gpp_pkg::K_ACT: nxt_s.act = wd[3:0];
          gpp_pkg::K_DIR: nxt_s.dir[dec.port] = wd & gpp_pkg::PIN_MASK[dec.port];
          gpp_pkg::K_DATA: nxt_s.data[dec.port] = (s_ff.data[dec.port] & s_ff.dir[dec.port])
                             | (wd & ~s_ff.dir[dec.port] & gpp_pkg::PIN_MASK[dec.port]);
          gpp_pkg::K_INV: nxt_s.inv[dec.port] = wd & gpp_pkg::PIN_MASK[dec.port];
          gpp_pkg::K_FSEL: nxt_s.fsel[dec.port] = wd & gpp_pkg::PIN_MASK[dec.port];
          gpp_pkg::K_IST: nxt_s.irq_st = s_ff.irq_st & ~wd[3:0];
          gpp_pkg::K_IMSK: nxt_s.irq_mask = wd[3:0];
          default: nxt_s.act = s_ff.act;
        endcase
      end
      if (!pwrite && dec.kind == gpp_pkg::K_STAT) begin
        nxt_s.stat[dec.port] = s_ff.stat[dec.port] & ~s_ff.prdata[7:0];
      end
    end
    for (int p = 0; p < gpp_pkg::NPORT; p++) begin
      edge_v[p*8 +: 8] = (pin_in[p*8 +: 8] ^ s_ff.prev[p]) & gpp_pkg::PIN_MASK[p]
                         & ~s_ff.fsel[p] & {8{s_ff.act[p] & s_ff.primed}};
      nxt_s.prev[p] = pin_in[p*8 +: 8];
      // Edge sets status, wins over clear
      nxt_s.stat[p] = nxt_s.stat[p] | edge_v[p*8 +: 8];
      if (|edge_v[p*8 +: 8]) begin
        nxt_s.irq_st[p] = 1'b1;
      end
      for (int b = 0; b < gpp_pkg::PIN_W; b++) begin
        if (s_ff.fsel[p][b]) begin
          nxt_s.pout[p][b] = alt_v[gpp_pkg::FSEL_SRC[p][b*3 +: 3]];
        end else begin
          nxt_s.pout[p][b] = s_ff.data[p][b] ^ s_ff.inv[p][b];
        end
      end
      nxt_s.poe[p] = ~s_ff.dir[p] & gpp_pkg::PIN_MASK[p] & {8{s_ff.act[p]}};
      if (prst_v[p]) begin
        nxt_s.dir[p] = gpp_pkg::DIR_RST[p];
        nxt_s.data[p] = '0;
        nxt_s.inv[p] = '0;
        nxt_s.stat[p] = '0;
        nxt_s.fsel[p] = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= gpp_pkg::RST_STATE;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign pin_out = s_ff.pout;
  assign pin_oe = s_ff.poe;
  assign irq = s_ff.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence seq_prep;
    clk_en && acc_prep;
  endsequence

  sequence seq_done;
    clk_en && acc_done;
  endsequence

  AST_INACTIVE_NO_DRIVE: assert property (
    clk_en && !s_ff.act[0] |=> pin_oe[7:0] == 8'h00)
    else $error("Inactive port two drives pins");

  AST_DIR_RESET: assert property (
    $rose(presetn) |-> s_ff.dir == gpp_pkg::DIR_RST)
    else $error("Direction registers not at reset value");

  AST_P3_BIT7: assert property (
    s_ff.dir[1][7] == 1'b0 && s_ff.stat[1][7] == 1'b0 && pin_oe[15] == 1'b0)
    else $error("Port three bit 7 not reserved");

  AST_OUT_DRIVE: assert property (
    clk_en && !s_ff.fsel[0][0] && s_ff.act[0] && !s_ff.dir[0][0] && !s_ff.inv[0][0]
    |=> pin_out[0] == $past(s_ff.data[0][0]) && pin_oe[0])
    else $error("Output pin does not follow data");

  AST_IN_WRITE_IGNORED: assert property (
    seq_done ##0 (pwrite && dec.kind == gpp_pkg::K_DATA && dec.port == 2'h0
    && s_ff.dir[0] == 8'hFF && !prst_v[0]) |=> $stable(s_ff.data[0]))
    else $error("Write to input data bit took effect");

  AST_INV_OUT: assert property (
    clk_en && !s_ff.fsel[0][1] && s_ff.inv[0][1]
    |=> pin_out[1] == !$past(s_ff.data[0][1]))
    else $error("Inversion not applied to output");

  AST_EDGE_SETS: assert property (
    clk_en && s_ff.act[0] && s_ff.primed && !s_ff.fsel[0][2] && !prst_v[0]
    && pin_in[2] != s_ff.prev[0][2] |=> s_ff.stat[0][2])
    else $error("Pin edge did not set status");

  AST_READ_CLEAR: assert property (
    (seq_prep ##1 seq_done) ##0 (!pwrite && dec.kind == gpp_pkg::K_STAT
    && dec.port == 2'h0) |=> ((s_ff.stat[0] & ~$past(edge_v[7:0])
    & $past(s_ff.prdata[7:0])) == 8'h00))
    else $error("Status not cleared by read");

  // Green LED on port two bit 7
  AST_P2_GREEN: assert property (
    clk_en && s_ff.fsel[0][7] |=> pin_out[7] == $past(green_led_out))
    else $error("Port two bit 7 not routed to green LED");

  // Sleep latch on port five bit 5
  AST_P5_SLEEP: assert property (
    clk_en && s_ff.fsel[3][5] |=> pin_out[29] == $past(sleep_s5_latch_out))
    else $error("Port five bit 5 not routed to sleep latch");

  // Mgmt interrupt on port four bit 1
  AST_P4_SMI: assert property (
    clk_en && s_ff.fsel[2][1] |=> pin_out[17] == $past(sys_mgmt_irq_out))
    else $error("Port four bit 1 not routed to mgmt interrupt");

  // Answer after one wait state
  AST_APB_ONE_WAIT: assert property (
    seq_prep |=> pready)
    else $error("APB answer timing wrong");

  // Answer stands one cycle
  AST_APB_RELEASE: assert property (
    seq_done |=> !pready)
    else $error("APB answer held too long");

  // Green LED on port three bit 6
  AST_P3_GREEN: assert property (
    clk_en && s_ff.fsel[1][6] |=> pin_out[14] == $past(green_led_out))
    else $error("Port three bit 6 not routed to green LED");

  // Yellow LED on port four bit 7
  AST_P4_YELLOW: assert property (
    clk_en && s_ff.fsel[2][7] |=> pin_out[23] == $past(yellow_led_out))
    else $error("Port four bit 7 not routed to yellow LED");

  // Overtemp on port two bit 4
  AST_P2_OVERTEMP: assert property (
    clk_en && s_ff.fsel[0][4] |=> pin_out[4] == $past(over_temp_out))
    else $error("Port two bit 4 not routed to overtemp");

  // Watchdog on port four bit 0
  AST_P4_WDT: assert property (
    clk_en && s_ff.fsel[2][0] |=> pin_out[16] == $past(watchdog_expire_out))
    else $error("Port four bit 0 not routed to watchdog");

  AST_PORT_RESET: assert property (
    clk_en && prst_v[2] |=> s_ff.dir[2] == gpp_pkg::DIR_RST[2]
    && s_ff.data[2] == 8'h00 && s_ff.fsel[2] == 8'h00)
    else $error("Port four reset did not restore defaults");

  AST_INPUT_NO_DRIVE: assert property (
    clk_en && s_ff.dir[2] == 8'hFF |=> pin_oe[23:16] == 8'h00)
    else $error("Port four input pins driven");

  AST_IRQ_LEVEL: assert property (
    clk_en && (s_ff.irq_st & s_ff.irq_mask) != 4'h0 |=> irq)
    else $error("Interrupt not raised for unmasked event");

endmodule // gpp_ports

`default_nettype wire

// ===== verification/gpp_board.sv
// Board model for the levels seen on the general purpose pins
`timescale 1ns/10ps
`default_nettype none

module gpp_board (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_level,
  output logic [31:0] pin_in
);
  // Driven pins read back their own level
  always_comb pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // gpp_board

`default_nettype wire

// ===== verification/tb_gpp_ports.sv
// Self-checking bench for the general purpose pin ports
`timescale 1ns/10ps
`default_nettype none

module tb_gpp_ports;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] prst = '0;
  logic [6:0] alt = '0;
  logic [31:0] ext = '0;
  logic [31:0] prdata;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic pready;
  logic pslverr;
  logic irq;
  logic [33:0] exp_q[$];
  logic [33:0] ent;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] m;
  logic [7:0] e;
  logic [7:0] i;
  logic [7:0] v;
  logic [31:0] srcmap [4] = '{32'h02340235, 32'h70235023, 32'h12351235, 32'h10651010};

  always #5 pclk = ~pclk;

  gpp_ports #(.ADDR_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_two_reset(prst[0]),
    .port_three_reset(prst[1]), .port_four_reset(prst[2]), .port_five_reset(prst[3]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .green_led_out(alt[0]),
    .yellow_led_out(alt[1]), .beeper_out(alt[2]), .sys_mgmt_irq_out(alt[3]),
    .over_temp_out(alt[4]), .watchdog_expire_out(alt[5]), .sleep_s5_latch_out(alt[6]),
    .irq(irq));

  gpp_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  task automatic check(input logic [32:0] seen, input logic [32:0] ex);
    n_tests++;
    if (seen !== ex) begin
      err_count++;
      $display("ERROR time %0t seen %0h expected %0h", $time, seen, ex);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      input logic [7:0] ex, input logic care, input logic err);
    exp_q.push_back({care, err, 24'h0, ex});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 8'h00, 1'b1, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex);
    apb(1'b0, idx, 8'h00, ex, 1'b1, 1'b0);
  endtask

  // Answer monitor and hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      close_out();
    end
    if (psel && penable && pready === 1'b1) begin
      ent = exp_q.pop_front();
      if (ent[33]) check({pslverr, prdata}, ent[32:0]);
    end
  end

  initial begin
    void'($urandom(32'h7EBD));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(gpp_pkg::IDX_ACT, 8'h00);
    for (int p = 0; p < 4; p++) begin
      m = (p == 1) ? 8'h7F : 8'hFF;
      rd(gpp_pkg::IDX_DIR[p], m);
      rd(gpp_pkg::IDX_DATA[p], 8'h00);
      rd(gpp_pkg::IDX_INV[p], 8'h00);
      rd(gpp_pkg::IDX_STAT[p], 8'h00);
      rd(gpp_pkg::IDX_FSEL[p], 8'h00);
    end
    apb(1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
    wr(gpp_pkg::IDX_ACT, 8'hFF);
    rd(gpp_pkg::IDX_ACT, 8'h0F);
    for (int p = 0; p < 4; p++) begin
      m = (p == 1) ? 8'h7F : 8'hFF;
      e = 8'($urandom()) | 8'h01;
      i = 8'($urandom());
      v = 8'($urandom());
      wr(gpp_pkg::IDX_DATA[p], 8'hFF);
      ext <= ext ^ ({24'h0, e} << (p * 8));
      repeat (3) @(posedge pclk);
      rd(gpp_pkg::IDX_DATA[p], e & m);
      wr(gpp_pkg::IDX_STAT[p], 8'hFF);
      rd(gpp_pkg::IDX_STAT[p], e & m);
      rd(gpp_pkg::IDX_STAT[p], 8'h00);
      wr(gpp_pkg::IDX_INV[p], i);
      rd(gpp_pkg::IDX_DATA[p], (e ^ i) & m);
      wr(gpp_pkg::IDX_DIR[p], 8'h00);
      repeat (2) @(posedge pclk);
      check({25'h0, pin_oe[p*8 +: 8] & m}, {25'h0, m});
      check({25'h0, pin_out[p*8 +: 8] & m}, {25'h0, i & m});
      wr(gpp_pkg::IDX_DATA[p], v);
      rd(gpp_pkg::IDX_DATA[p], v & m);
      @(posedge pclk);
      check({25'h0, pin_out[p*8 +: 8] & m}, {25'h0, (v ^ i) & m});
      apb(1'b0, gpp_pkg::IDX_STAT[p], 8'h00, 8'h00, 1'b0, 1'b0);
    end
    for (int p = 0; p < 4; p++) begin
      wr(gpp_pkg::IDX_FSEL[p], 8'hFF);
      rd(gpp_pkg::IDX_FSEL[p], (p == 1) ? 8'h7F : 8'hFF);
      for (int k = 0; k < 6; k++) begin
        alt <= 7'($urandom());
        repeat (3) @(posedge pclk);
        for (int b = 0; b < 8; b++) begin
          if (srcmap[p][b*4 +: 4] != 4'h7)
            check({32'h0, pin_out[p*8+b]}, {32'h0, alt[srcmap[p][b*4 +: 3]]});
        end
      end
    end
    prst <= 4'h4;
    @(posedge pclk);
    prst <= 4'h0;
    @(posedge pclk);
    rd(gpp_pkg::IDX_DIR[2], 8'hFF);
    rd(gpp_pkg::IDX_FSEL[2], 8'h00);
    rd(gpp_pkg::IDX_DIR[3], 8'h00);
    wr(gpp_pkg::IDX_IRQ_STAT, 8'h0F);
    wr(gpp_pkg::IDX_IRQ_MASK, 8'h04);
    ext <= ext ^ 32'h00FF0000;
    repeat (3) @(posedge pclk);
    check({32'h0, irq}, 33'h1);
    rd(gpp_pkg::IDX_IRQ_STAT, 8'h04);
    wr(gpp_pkg::IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    wr(gpp_pkg::IDX_IRQ_MASK, 8'h04);
    wr(gpp_pkg::IDX_IRQ_STAT, 8'h04);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    // Edge held off while the clock enable is low
    clk_en <= 1'b0;
    ext <= ext ^ 32'h00010000;
    repeat (3) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    check({32'h0, irq}, 33'h1);
    wr(gpp_pkg::IDX_IRQ_STAT, 8'h04);
    wr(gpp_pkg::IDX_ACT, 8'h00);
    repeat (2) @(posedge pclk);
    check({1'b0, pin_oe}, 33'h0);
    close_out();
  end
endmodule // tb_gpp_ports

`default_nettype wire
